// >>> hmc_pkg.sv
// Purpose: Shared constants and types for the health monitor control block
// Assumes: 40 MHz system clock, 32-bit APB, 10-bit converter results
// Notes: Register byte address is four times the register index
package hmc_pkg;
   // Converter and channel plan
   localparam int RES_W = 10;
   localparam int CHAN_W = 5;
   localparam int NUM_AUX = 16;
   localparam int NUM_CHAN = 4 + NUM_AUX;
   localparam logic [CHAN_W-1:0] CH_TEMP = 5'h00;
   localparam logic [CHAN_W-1:0] CH_VINT = 5'h01;
   localparam logic [CHAN_W-1:0] CH_VAUX = 5'h02;
   localparam logic [CHAN_W-1:0] CH_EXT = 5'h03;
   localparam logic [CHAN_W-1:0] CH_AUX0 = 5'h04;
   localparam logic [CHAN_W-1:0] CH_LAST = 5'h13;

   // Sampling pace: 200 kSPS gives the least spacing between starts
   localparam int CLK_PERIOD_PS = 25000;
   localparam int SAMPLE_PERIOD_NS = 5000;
   localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] PACE_RELOAD = 8'(SAMPLE_CYCLES - 1);

   // Register indices (byte address = 4 * index)
   localparam logic [6:0] IDX_RESULT0 = 7'h00;
   localparam logic [6:0] IDX_TEMP_MAX = 7'h20;
   localparam logic [6:0] IDX_VINT_MAX = 7'h21;
   localparam logic [6:0] IDX_VAUX_MAX = 7'h22;
   localparam logic [6:0] IDX_TEMP_MIN = 7'h24;
   localparam logic [6:0] IDX_VINT_MIN = 7'h25;
   localparam logic [6:0] IDX_VAUX_MIN = 7'h26;
   localparam logic [6:0] IDX_STATUS = 7'h3f;
   localparam logic [6:0] IDX_CTRL = 7'h40;
   localparam logic [6:0] IDX_SEQ_LO = 7'h41;
   localparam logic [6:0] IDX_SEQ_HI = 7'h42;
   localparam logic [6:0] IDX_TEMP_HI = 7'h50;
   localparam logic [6:0] IDX_VINT_HI = 7'h51;
   localparam logic [6:0] IDX_OT_HI = 7'h53;
   localparam logic [6:0] IDX_TEMP_LO = 7'h54;
   localparam logic [6:0] IDX_VINT_LO = 7'h55;
   localparam logic [6:0] IDX_OT_LO = 7'h57;
   localparam logic [6:0] IDX_IRQ_STAT = 7'h60;
   localparam logic [6:0] IDX_IRQ_MASK = 7'h61;

   // Control register fields
   localparam int CTRL_SEQ_EN = 0;
   localparam int CTRL_PD_EN = 1;
   localparam int CTRL_AVG_LSB = 2;
   localparam int CTRL_USER_RST = 4;

   // Interrupt status bits
   localparam int IRQ_W = 5;
   localparam int IRQ_EOC = 0;
   localparam int IRQ_EOS = 1;
   localparam int IRQ_ALM0 = 2;
   localparam int IRQ_ALM1 = 3;
   localparam int IRQ_OT = 4;

   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h1;
   localparam logic [NUM_CHAN-1:0] SEQ_RST = 20'h00007;
   localparam logic [RES_W-1:0] OT_HI_RST = 10'h329;
   localparam logic [RES_W-1:0] OT_LO_RST = 10'h2f0;
   localparam logic [RES_W-1:0] THR_HI_RST = 10'h3ff;
   localparam logic [RES_W-1:0] THR_LO_RST = 10'h000;
   localparam logic [RES_W-1:0] MAX_RST = 10'h000;
   localparam logic [RES_W-1:0] MIN_RST = 10'h3ff;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

   typedef enum logic [1:0] {
      SEQ_SCAN = 2'b00,
      SEQ_START = 2'b01,
      SEQ_WAIT = 2'b11,
      SEQ_STORE = 2'b10
   } hmc_seq_e;

   typedef struct packed {
      logic en;
      logic [CHAN_W-1:0] addr;
      logic [RES_W-1:0] data;
   } hmc_memwr_s;

   typedef struct packed {
      logic start;
      logic [CHAN_W-1:0] channel;
   } hmc_adccmd_s;
endpackage : hmc_pkg

// >>> hmc_result_ram.sv
// Purpose: Latest-result store, one word per measurement channel
// Assumes: One write and one read port on the system clock
// Notes: Read data comes out of a register one edge after the address
`timescale 1ns/1ps
module hmc_result_ram (
   input wire logic sys_clk,
   input hmc_pkg::hmc_memwr_s wr,
   input wire logic [hmc_pkg::CHAN_W-1:0] rdAddr,
   output logic [hmc_pkg::RES_W-1:0] rdData
);
   import hmc_pkg::*;

   logic [RES_W-1:0] mem [0:(1<<CHAN_W)-1];

   always_ff @(posedge sys_clk) begin
      if (wr.en) begin
         mem[wr.addr] <= wr.data;
      end
      rdData <= mem[rdAddr];
   end
endmodule : hmc_result_ram

// >>> hmc_ctrl.sv
// Purpose: Sequencer, averaging, min/max, alarms and APB registers of the health monitor
// Assumes: Converter answers each adcStart with one adcDone pulse and its result
// Notes: Analog muxing stays outside; adcChannel selects sensor, dedicated or aux pair
// Operation
// - Convert selected channels to 10-bit results, at most 200 kSPS.
// - Offer one dedicated external pair plus sixteen auxiliary pairs as channels.
// - Result becomes readable when conversion-done or sequence-done pulses.
// - Keep max and min per internal sensor since reset or user reset.
// - Sequencer steps through the selected channels without further commands.
// - Programmable averaging of successive results reduces noise.
// - Alarm output active while a sensor result is outside its thresholds.
// - Overheat alarm sets above upper limit, 125 C after reset.
// - Overheat alarm holds until temperature falls below the lower limit.
// - With power-down enabled, power down as overheat goes active.
// - With power-down enabled, power up when overheat clears.
// - All features changeable at run time through the register port.
// - Control registers start from values fixed at instantiation.
// - Monitoring runs from reset; results readable over the scan port.
// - Port carries 16-bit data words and a 7-bit register select.
// - Each port access completes with a data-ready answer.
// - Alarm bit 0 is temperature, bit 1 is core supply.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module hmc_ctrl #(
   parameter logic [3:0] INIT_CTRL = hmc_pkg::CTRL_RST,
   parameter logic [hmc_pkg::NUM_CHAN-1:0] INIT_SEQ = hmc_pkg::SEQ_RST,
   parameter logic [hmc_pkg::RES_W-1:0] INIT_OT_HI = hmc_pkg::OT_HI_RST,
   parameter logic [hmc_pkg::RES_W-1:0] INIT_OT_LO = hmc_pkg::OT_LO_RST,
   parameter logic [hmc_pkg::RES_W-1:0] INIT_THR_HI = hmc_pkg::THR_HI_RST,
   parameter logic [hmc_pkg::RES_W-1:0] INIT_THR_LO = hmc_pkg::THR_LO_RST
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output hmc_pkg::hmc_adccmd_s adcCmd,
   input wire logic adcDone,
   input wire logic [hmc_pkg::RES_W-1:0] adcResult,
   input wire logic scanReq,
   input wire logic [hmc_pkg::CHAN_W-1:0] scanIdx,
   output logic [hmc_pkg::RES_W-1:0] scanData,
   output logic scanValid,
   output logic conversionDone,
   output logic sequenceDone,
   output logic [1:0] alarmOut,
   output logic overheatAlarm,
   output logic powerDown,
   output logic irq
);
   import hmc_pkg::*;

   typedef struct packed {
      hmc_seq_e fsm;
      logic [CHAN_W-1:0] chan;
      logic [5:0] avgCnt;
      logic [15:0] acc;
      logic [7:0] pace;
      logic [2:0][RES_W-1:0] maxRec;
      logic [2:0][RES_W-1:0] minRec;
      logic seqEnable;
      logic pdEnable;
      logic [1:0] avgSel;
      logic [NUM_CHAN-1:0] seqSel;
      logic [RES_W-1:0] otHi;
      logic [RES_W-1:0] otLo;
      logic [1:0][RES_W-1:0] thrHi;
      logic [1:0][RES_W-1:0] thrLo;
      logic [1:0] alarm;
      logic overheat;
      logic powerDown;
      logic convDone;
      logic seqDone;
      logic [IRQ_W-1:0] irqStat;
      logic [IRQ_W-1:0] irqMask;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic memPend;
      logic scanPend;
      logic [RES_W-1:0] scanData;
      logic scanValid;
      hmc_adccmd_s adcCmd;
      hmc_memwr_s memWr;
   } hmc_state_s;

   hmc_state_s s;
   hmc_state_s next_s;
   logic [6:0] regIdx;
   logic inRange;
   logic isMem;
   logic apbMemReq;
   logic [CHAN_W-1:0] rdAddr;
   logic [RES_W-1:0] memRdData;
   logic [15:0] regRd;
   logic regHit;

   function automatic logic [CHAN_W-1:0] highestSel(input logic [NUM_CHAN-1:0] sel);
      logic [CHAN_W-1:0] hi;
      hi = '0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (sel[i]) begin
            hi = CHAN_W'(i);
         end
      end
      return hi;
   endfunction : highestSel

   assign regIdx = paddr[8:2];
   assign inRange = (paddr[11:9] == 3'h0);
   assign isMem = inRange && (regIdx < 7'(NUM_CHAN));
   assign apbMemReq = psel && !s.pready && isMem;
   // APB owns the read port; scan reads only take idle cycles
   assign rdAddr = apbMemReq ? paddr[6:2] : scanIdx;

   hmc_result_ram hmc_result_ram_inst (
      .sys_clk(sys_clk),
      .wr(s.memWr),
      .rdAddr(rdAddr),
      .rdData(memRdData)
   );

   always_comb begin
      regRd = '0;
      regHit = inRange;
      unique case (regIdx)
         IDX_TEMP_MAX: regRd = 16'(s.maxRec[0]);
         IDX_VINT_MAX: regRd = 16'(s.maxRec[1]);
         IDX_VAUX_MAX: regRd = 16'(s.maxRec[2]);
         IDX_TEMP_MIN: regRd = 16'(s.minRec[0]);
         IDX_VINT_MIN: regRd = 16'(s.minRec[1]);
         IDX_VAUX_MIN: regRd = 16'(s.minRec[2]);
         IDX_STATUS: regRd = {11'h000, s.fsm != SEQ_SCAN, s.powerDown, s.overheat, s.alarm};
         IDX_CTRL: regRd = {12'h000, s.avgSel, s.pdEnable, s.seqEnable};
         IDX_SEQ_LO: regRd = s.seqSel[15:0];
         IDX_SEQ_HI: regRd = {12'h000, s.seqSel[NUM_CHAN-1:16]};
         IDX_TEMP_HI: regRd = 16'(s.thrHi[0]);
         IDX_VINT_HI: regRd = 16'(s.thrHi[1]);
         IDX_OT_HI: regRd = 16'(s.otHi);
         IDX_TEMP_LO: regRd = 16'(s.thrLo[0]);
         IDX_VINT_LO: regRd = 16'(s.thrLo[1]);
         IDX_OT_LO: regRd = 16'(s.otLo);
         IDX_IRQ_STAT: regRd = 16'(s.irqStat);
         IDX_IRQ_MASK: regRd = 16'(s.irqMask);
         default: regHit = 1'b0;
      endcase
   end

   always_comb begin
      logic [IRQ_W-1:0] irqSet;
      logic [IRQ_W-1:0] irqClr;
      logic [5:0] avgLast;
      logic [15:0] sum;
      logic [RES_W-1:0] avgRes;
      logic userReset;
      logic wrDone;
      irqSet = '0;
      irqClr = '0;
      avgLast = '0;
      sum = '0;
      avgRes = '0;
      userReset = 1'b0;
      wrDone = psel && penable && s.pready && pwrite;
      next_s = s;
      next_s.convDone = 1'b0;
      next_s.seqDone = 1'b0;
      next_s.scanValid = 1'b0;
      next_s.memWr.en = 1'b0;
      next_s.adcCmd.start = 1'b0;
      if (s.pace != 8'h00) begin
         next_s.pace = s.pace - 8'h01;
      end

      if (psel && penable && s.pready) begin
         next_s.pready = 1'b0;
         next_s.pslverr = 1'b0;
      end else if (psel && !s.pready) begin
         if (isMem) begin
            // Result words need one extra cycle for the registered read
            if (s.memPend) begin
               next_s.memPend = 1'b0;
               next_s.prdata = 32'(memRdData);
               next_s.pslverr = 1'b0;
               next_s.pready = 1'b1;
            end else begin
               next_s.memPend = 1'b1;
            end
         end else begin
            next_s.prdata = 32'(regRd);
            next_s.pslverr = !regHit;
            next_s.pready = 1'b1;
         end
      end

      if (s.scanPend) begin
         next_s.scanPend = 1'b0;
         next_s.scanData = memRdData;
         next_s.scanValid = 1'b1;
      end else if (scanReq && !apbMemReq && !s.scanValid) begin
         next_s.scanPend = 1'b1;
      end

      if (wrDone && regHit) begin
         unique case (regIdx)
            IDX_CTRL: begin
               next_s.seqEnable = pwdata[CTRL_SEQ_EN];
               next_s.pdEnable = pwdata[CTRL_PD_EN];
               next_s.avgSel = pwdata[CTRL_AVG_LSB +: 2];
               userReset = pwdata[CTRL_USER_RST];
            end
            IDX_SEQ_LO: next_s.seqSel[15:0] = pwdata[15:0];
            IDX_SEQ_HI: next_s.seqSel[NUM_CHAN-1:16] = pwdata[NUM_CHAN-17:0];
            IDX_TEMP_HI: next_s.thrHi[0] = pwdata[RES_W-1:0];
            IDX_VINT_HI: next_s.thrHi[1] = pwdata[RES_W-1:0];
            IDX_OT_HI: next_s.otHi = pwdata[RES_W-1:0];
            IDX_TEMP_LO: next_s.thrLo[0] = pwdata[RES_W-1:0];
            IDX_VINT_LO: next_s.thrLo[1] = pwdata[RES_W-1:0];
            IDX_OT_LO: next_s.otLo = pwdata[RES_W-1:0];
            IDX_IRQ_STAT: irqClr = pwdata[IRQ_W-1:0];
            IDX_IRQ_MASK: next_s.irqMask = pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      unique case (s.avgSel)
         2'd0: avgLast = 6'd0;
         2'd1: avgLast = 6'd3;
         2'd2: avgLast = 6'd15;
         2'd3: avgLast = 6'd63;
      endcase
      sum = s.acc + 16'(adcResult);

      unique case (s.fsm)
         SEQ_SCAN: begin
            if (s.seqEnable && (s.seqSel != '0)) begin
               if (s.seqSel[s.chan]) begin
                  next_s.fsm = SEQ_START;
               end else begin
                  next_s.chan = (s.chan == CH_LAST) ? CH_TEMP : s.chan + 5'h01;
               end
            end
         end
         SEQ_START: begin
            if (s.pace == 8'h00) begin
               next_s.adcCmd.start = 1'b1;
               next_s.adcCmd.channel = s.chan;
               next_s.pace = PACE_RELOAD;
               next_s.fsm = SEQ_WAIT;
            end
         end
         SEQ_WAIT: begin
            if (adcDone) begin
               next_s.acc = sum;
               if (s.avgCnt == avgLast) begin
                  next_s.avgCnt = '0;
                  next_s.fsm = SEQ_STORE;
               end else begin
                  next_s.avgCnt = s.avgCnt + 6'd1;
                  next_s.fsm = SEQ_START;
               end
            end
         end
         SEQ_STORE: begin
            avgRes = RES_W'(s.acc >> {s.avgSel, 1'b0});
            next_s.acc = '0;
            next_s.memWr.en = 1'b1;
            next_s.memWr.addr = s.chan;
            next_s.memWr.data = avgRes;
            next_s.convDone = 1'b1;
            irqSet[IRQ_EOC] = 1'b1;
            if (s.chan == highestSel(s.seqSel)) begin
               next_s.seqDone = 1'b1;
               irqSet[IRQ_EOS] = 1'b1;
            end
            if (s.chan <= CH_VAUX) begin
               if (avgRes > s.maxRec[s.chan[1:0]]) begin
                  next_s.maxRec[s.chan[1:0]] = avgRes;
               end
               if (avgRes < s.minRec[s.chan[1:0]]) begin
                  next_s.minRec[s.chan[1:0]] = avgRes;
               end
            end
            if (s.chan <= CH_VINT) begin
               next_s.alarm[s.chan[0]] = (avgRes > s.thrHi[s.chan[0]]) ||
                  (avgRes < s.thrLo[s.chan[0]]);
               if (next_s.alarm[s.chan[0]] && !s.alarm[s.chan[0]]) begin
                  irqSet[IRQ_ALM0 + 32'(s.chan[0])] = 1'b1;
               end
            end
            if (s.chan == CH_TEMP) begin
               if (avgRes > s.otHi) begin
                  next_s.overheat = 1'b1;
               end else if (avgRes < s.otLo) begin
                  next_s.overheat = 1'b0;
               end
               irqSet[IRQ_OT] = next_s.overheat && !s.overheat;
            end
            next_s.chan = (s.chan == CH_LAST) ? CH_TEMP : s.chan + 5'h01;
            next_s.fsm = SEQ_SCAN;
         end
      endcase

      if (userReset) begin
         next_s.fsm = SEQ_SCAN;
         next_s.chan = CH_TEMP;
         next_s.avgCnt = '0;
         next_s.acc = '0;
         next_s.maxRec = {3{MAX_RST}};
         next_s.minRec = {3{MIN_RST}};
      end

      next_s.powerDown = next_s.pdEnable && next_s.overheat;
      // New events win over a clear in the same cycle
      next_s.irqStat = (s.irqStat & ~irqClr) | irqSet;
      next_s.irq = |(next_s.irqStat & next_s.irqMask);
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.fsm <= SEQ_SCAN;
         s.chan <= CH_TEMP;
         s.maxRec <= {3{MAX_RST}};
         s.minRec <= {3{MIN_RST}};
         s.seqEnable <= INIT_CTRL[CTRL_SEQ_EN];
         s.pdEnable <= INIT_CTRL[CTRL_PD_EN];
         s.avgSel <= INIT_CTRL[CTRL_AVG_LSB +: 2];
         s.seqSel <= INIT_SEQ;
         s.otHi <= INIT_OT_HI;
         s.otLo <= INIT_OT_LO;
         s.thrHi <= {2{INIT_THR_HI}};
         s.thrLo <= {2{INIT_THR_LO}};
         s.irqMask <= IRQ_MASK_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign adcCmd = s.adcCmd;
   assign scanData = s.scanData;
   assign scanValid = s.scanValid;
   assign conversionDone = s.convDone;
   assign sequenceDone = s.seqDone;
   assign alarmOut = s.alarm;
   assign overheatAlarm = s.overheat;
   assign powerDown = s.powerDown;
   assign irq = s.irq;
endmodule : hmc_ctrl

// >>> hmc_ctrl_assertions.sv
// Purpose: Port checks for the health monitor controller
// Assumes: Bound onto hmc_ctrl, one clock domain
// Notes: Start spacing measured by a saturating gap counter
`timescale 1ns/1ps
module hmc_ctrl_assertions (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input hmc_pkg::hmc_adccmd_s adcCmd,
   input wire logic adcDone,
   input wire logic conversionDone,
   input wire logic sequenceDone,
   input wire logic overheatAlarm,
   input wire logic powerDown
);
   import hmc_pkg::*;
   logic [7:0] gap;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // Saturates so a long idle never wraps into a false short gap
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) gap <= 8'hff;
      else if (adcCmd.start) gap <= 8'h00;
      else if (gap != 8'hff) gap <= gap + 8'h01;
   end
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held");
   a_ready_bounded: assert property (psel && !penable |-> ##[1:2] pready)
      else $error("pready late");
   a_unmapped_error: assert property (pready && paddr[11:9] != 3'h0 |-> pslverr)
      else $error("no pslverr");
   a_refused_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read has data");
   a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
      else $error("data above bit 15");
   a_start_spacing: assert property (adcCmd.start |-> gap >= 8'hc7)
      else $error("starts too close");
   a_seq_with_conv: assert property (sequenceDone |-> conversionDone)
      else $error("lone sequence done");
   a_conv_cause: assert property (conversionDone |-> $past(adcDone, 2))
      else $error("done without answer");
   a_pd_follows: assert property (powerDown |-> overheatAlarm)
      else $error("power down without overheat");
endmodule : hmc_ctrl_assertions

// >>> hmc_adc_model.sv
// Purpose: Converter stand-in, one answer per start
// Assumes: Delay and value come from the bench
// Notes: Result lines toggle between answers so stale data never matches
`timescale 1ns/1ps
module hmc_adc_model (
   input wire logic sys_clk,
   input hmc_pkg::hmc_adccmd_s adcCmd,
   input wire logic [9:0] value,
   input wire logic [7:0] dly,
   input wire logic wobble,
   output logic adcDone,
   output logic [9:0] adcResult
);
   import hmc_pkg::*;
   int cnt = -1;
   logic odd = 1'b0;
   logic done = 1'b0;
   logic [9:0] res = 10'h000;
   assign adcDone = done;
   assign adcResult = res;
   always @(posedge sys_clk) begin
      done <= 1'b0;
      res <= ~res;
      if (adcCmd.start) cnt <= int'(dly);
      else if (cnt > 0) cnt <= cnt - 1;
      else if (cnt == 0) begin
         done <= 1'b1;
         res <= value + (wobble && odd ? 10'h002 : 10'h000);
         odd <= !odd;
         cnt <= -1;
      end
   end
endmodule : hmc_adc_model

// >>> hmc_ctrl_bench.sv
// Purpose: Self-checking bench for the health monitor controller
// Assumes: APB master at 40 MHz, converter model on the far side
// Notes: Sensor values change only between sequence waits
`timescale 1ns/1ps
module hmc_ctrl_bench;
   import hmc_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic scanReq = 1'b0;
   logic [4:0] scanIdx = 5'h00;
   logic [7:0] dly = 8'h01;
   logic wobble = 1'b0;
   logic [31:0] seed = 32'h0000004d;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, adcDone, scanValid, conversionDone, sequenceDone;
   logic overheatAlarm, powerDown, irq;
   logic [9:0] adcResult, scanData, modelVal, tmax, tmin;
   logic [9:0] chanVal [NUM_CHAN];
   logic [1:0] alarmOut;
   hmc_adccmd_s adcCmd;
   int mismatches = 0;
   int total_checks = 0;
   hmc_ctrl hmc_ctrl_inst (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .adcCmd, .adcDone, .adcResult, .scanReq, .scanIdx,
      .scanData, .scanValid, .conversionDone, .sequenceDone, .alarmOut, .overheatAlarm,
      .powerDown, .irq);
   hmc_adc_model hmc_adc_model_inst (.sys_clk, .adcCmd, .value(modelVal), .dly, .wobble,
      .adcDone, .adcResult);
   assign modelVal = chanVal[adcCmd.channel];
   initial forever #12.5 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Slow and prompt converter answers alike
   always @(posedge sys_clk) if (adcCmd.start) dly <= 8'(rnd() % 150 + 1);
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic hang;
      mismatches++;
      close_out();
   endtask : hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic wr(input logic [6:0] i, input logic [31:0] d);
      apb(1'b1, {3'h0, i, 2'h0}, d);
   endtask : wr
   task automatic rdchk(input logic [6:0] i, input logic [31:0] e);
      apb(1'b0, {3'h0, i, 2'h0}, 32'h0);
      check(rd, e);
   endtask : rdchk
   task automatic wait_seq(input int k);
      int n;
      repeat (k) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (sequenceDone !== 1'b1 && n < 9000);
         if (n >= 9000) hang();
      end
   endtask : wait_seq
   task automatic set_temp(input logic [9:0] v);
      chanVal[0] <= v;
      wait_seq(2);
      if (v > tmax) tmax = v;
      if (v < tmin) tmin = v;
   endtask : set_temp
   initial begin
      logic [6:0] ri [7];
      logic [31:0] rv [7];
      logic [31:0] r;
      ri = '{IDX_CTRL, IDX_SEQ_LO, IDX_OT_HI, IDX_OT_LO, IDX_TEMP_HI, IDX_TEMP_LO, IDX_IRQ_MASK};
      rv = '{32'h1, 32'h7, 32'h329, 32'h2f0, 32'h3ff, 32'h0, 32'h0};
      // Kept below the overheat limit so no alarm fires early
      foreach (chanVal[i]) chanVal[i] = 10'(rnd() % 32'h2f0);
      tmax = chanVal[0];
      tmin = chanVal[0];
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      foreach (ri[i]) rdchk(ri[i], rv[i]); // start values
      apb(1'b0, 12'h800, 32'h0);
      check(err, 1'b1); // address beyond map refused
      apb(1'b0, {3'h0, 7'h30, 2'h0}, 32'h0);
      check(rd, 32'h0); // unlisted index reads zero
      check(err, 1'b1); // unlisted index refused
      wait_seq(1);
      for (int c = 0; c < 3; c++) rdchk(7'(c), 32'(chanVal[c])); // latest results
      rdchk(IDX_VINT_MAX, 32'(chanVal[1])); // core maximum
      rdchk(IDX_VINT_MIN, 32'(chanVal[1])); // core minimum
      r = rnd() & 32'h3ff;
      wr(IDX_VINT_LO, r);
      rdchk(IDX_VINT_LO, r); // run-time write
      wr(IDX_VINT_LO, 32'h0);
      wr(IDX_TEMP_MAX, 32'h0);
      rdchk(IDX_TEMP_MAX, 32'(chanVal[0])); // read-only kept
      wr(IDX_IRQ_MASK, 32'h1 << IRQ_ALM0);
      set_temp(10'h200);
      wr(IDX_TEMP_HI, 32'h1ff);
      wait_seq(2);
      check(alarmOut, 2'b01); // temperature alarm bit
      check(irq, 1'b1); // alarm interrupt
      wr(IDX_IRQ_STAT, 32'h1 << IRQ_ALM0);
      @(posedge sys_clk);
      check(irq, 1'b0); // interrupt cleared
      wr(IDX_TEMP_HI, 32'h3ff);
      wr(IDX_VINT_LO, 32'h3ff);
      wait_seq(2);
      check(alarmOut, 2'b10); // core supply alarm bit
      wr(IDX_VINT_LO, 32'h0);
      wr(IDX_CTRL, 32'h3);
      set_temp(10'h340);
      check({overheatAlarm, powerDown}, 2'b11); // overheat powers down
      apb(1'b0, {3'h0, IDX_STATUS, 2'h0}, 32'h0);
      check(rd[3:0], 4'hc); // status shows overheat
      set_temp(10'h300);
      check({overheatAlarm, powerDown}, 2'b11); // held in hysteresis
      set_temp(10'h2e0);
      check({overheatAlarm, powerDown}, 2'b00); // cleared below limit
      rdchk(IDX_TEMP_MAX, 32'(tmax)); // largest temperature
      rdchk(IDX_TEMP_MIN, 32'(tmin)); // smallest temperature
      wr(IDX_CTRL, 32'h13);
      wait_seq(1);
      rdchk(IDX_TEMP_MAX, 32'h2e0); // records restarted
      rdchk(IDX_TEMP_MIN, 32'h2e0); // records restarted
      rdchk(IDX_CTRL, 32'h3); // configuration kept
      scanIdx <= CH_TEMP;
      scanReq <= 1'b1;
      for (r = 0; r < 20 && scanValid !== 1'b1; r++) @(posedge sys_clk);
      scanReq <= 1'b0;
      if (r >= 20) hang();
      check(scanData, 32'h2e0); // scan port read
      wr(IDX_SEQ_LO, 32'h8);
      wr(IDX_SEQ_HI, 32'h8);
      wait_seq(2);
      rdchk(7'(CH_EXT), 32'(chanVal[3])); // dedicated pair
      rdchk(7'(CH_LAST), 32'(chanVal[19])); // last aux pair
      wobble <= 1'b1;
      wr(IDX_CTRL, 32'h7);
      wait_seq(2);
      rdchk(7'(CH_EXT), 32'(chanVal[3]) + 32'h1); // four-sample mean
      close_out();
   end
endmodule : hmc_ctrl_bench
bind hmc_ctrl hmc_ctrl_assertions hmc_ctrl_assertions_inst (.sys_clk, .reset_n, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .adcCmd, .adcDone,
   .conversionDone, .sequenceDone, .overheatAlarm, .powerDown);
